// >>> annp_pkg.sv
package annp_pkg;
  // register word addresses
  localparam logic [4:0] ANNP_ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ANNP_ADDR_LOCAL_NP = 5'h07;
  localparam logic [4:0] ANNP_ADDR_PARTNER_NP = 5'h08;
  localparam logic [4:0] ANNP_ADDR_IRQ_STATUS = 5'h18;
  localparam logic [4:0] ANNP_ADDR_IRQ_CLEAR = 5'h19;
  localparam logic [4:0] ANNP_ADDR_IRQ_ENABLE = 5'h1A;
  // expansion register fields
  localparam int ANNP_EXP_PDF_BIT = 4;
  localparam int ANNP_EXP_LPNP_BIT = 3;
  localparam int ANNP_EXP_LDNP_BIT = 2;
  localparam int ANNP_EXP_PR_BIT = 1;
  localparam int ANNP_EXP_LPAN_BIT = 0;
  // next page register fields
  localparam int ANNP_NP_NEXT_BIT = 15;
  localparam int ANNP_NP_ACK_BIT = 14;
  localparam int ANNP_NP_MSG_BIT = 13;
  localparam int ANNP_NP_ACK2_BIT = 12;
  localparam int ANNP_NP_TOG_BIT = 11;
  localparam int ANNP_NP_CODE_W = 11;
  // reset values
  localparam logic ANNP_RST_NEXT = 1'b0;
  localparam logic ANNP_RST_MSG = 1'b1;
  localparam logic ANNP_RST_ACK2 = 1'b0;
  localparam logic [10:0] ANNP_RST_CODE = 11'h001;
  // interrupt status bits
  localparam int ANNP_IRQ_PDF_BIT = 0;
  localparam int ANNP_IRQ_PR_BIT = 1;
  localparam int ANNP_IRQ_W = 2;
endpackage

// >>> annp_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - latch parallel detection fault high at expansion bit 4
// RULE2 - latch page received high at expansion bit 1
// RULE3 - expansion bit 3 shows partner next page ability
// RULE4 - expansion bit 2 reads fixed one, local next page able
// RULE5 - expansion bit 0 shows partner autoneg ability, reset zero
// RULE6 - outgoing next page request bit 15 writable, reset zero
// RULE7 - message page bit 13 writable, reset one
// RULE8 - code is message code when bit 13 set, else unformatted
// RULE9 - acknowledge-2 bit 12 writable, reset zero
// RULE10 - toggle bit 11 is inverse of last exchanged toggle
// RULE11 - outgoing code field resets to null page value one
// RULE12 - partner acknowledge shown at partner register bit 14
// RULE13 - partner next page, message, ack2, toggle bits read-only, reset zero
// RULE14 - latched flags clear on read unless condition still present
module annp_regs
  import annp_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic par_det_fault,
  input wire logic page_rx_pulse,
  input wire logic partner_np_able,
  input wire logic partner_an_able,
  input wire logic [15:0] partner_word,
  input wire logic page_exchanged,
  input wire logic exchanged_toggle,
  output logic np_request,
  output logic np_message,
  output logic np_ack2,
  output logic np_toggle,
  output logic [10:0] np_code,
  output logic np_code_is_msg,
  output logic irq
);

  // decode and word layout assume at least five address bits and a 16-bit word
  if (ADDR_W < 5 || DATA_W != 16) begin : g_bad_params
    $error("annp_regs: ADDR_W must be >= 5 and DATA_W must be 16");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] r);
    hit = (a == ADDR_W'(r));
  endfunction

  logic rd_exp;
  logic wr_np;
  logic wr_clr;
  logic wr_en;
  assign rd_exp = reg_rd && hit(reg_addr, ANNP_ADDR_EXPANSION);
  assign wr_np = reg_wr && hit(reg_addr, ANNP_ADDR_LOCAL_NP);
  assign wr_clr = reg_wr && hit(reg_addr, ANNP_ADDR_IRQ_CLEAR);
  assign wr_en = reg_wr && hit(reg_addr, ANNP_ADDR_IRQ_ENABLE);

  // ----------------------------------------------------------------
  // latched-high expansion flags
  // ----------------------------------------------------------------
  logic pdf_r;
  logic pr_r;

  // RULE1 fault latch
  // RULE14 read clears unless fault persists; a new event wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pdf_r <= 1'b0;
    end else if (par_det_fault) begin
      pdf_r <= 1'b1;
    end else if (rd_exp) begin
      pdf_r <= 1'b0;
    end
  end

  // RULE2 page latch
  // RULE14 read clears unless a page arrives the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pr_r <= 1'b0;
    end else if (page_rx_pulse) begin
      pr_r <= 1'b1;
    end else if (rd_exp) begin
      pr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outgoing next page
  // ----------------------------------------------------------------
  logic np_next_r;
  logic np_msg_r;
  logic np_ack2_r;
  logic [10:0] np_code_r;
  logic tog_r;

  // RULE6 RULE7 RULE9 writable control bits
  // RULE11 code resets to null page
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      np_next_r <= ANNP_RST_NEXT;
      np_msg_r <= ANNP_RST_MSG;
      np_ack2_r <= ANNP_RST_ACK2;
      np_code_r <= ANNP_RST_CODE;
    end else if (wr_np) begin
      np_next_r <= reg_wdata[ANNP_NP_NEXT_BIT];
      np_msg_r <= reg_wdata[ANNP_NP_MSG_BIT];
      np_ack2_r <= reg_wdata[ANNP_NP_ACK2_BIT];
      np_code_r <= reg_wdata[ANNP_NP_CODE_W-1:0];
    end
  end

  // RULE10 toggle follows inverse of last exchanged word
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tog_r <= 1'b0;
    end else if (page_exchanged) begin
      tog_r <= ~exchanged_toggle;
    end
  end

  // ----------------------------------------------------------------
  // partner next page capture
  // ----------------------------------------------------------------
  logic [15:0] partner_r;
  logic lpnp_r;
  logic lpan_r;

  // RULE12 RULE13 captured on each received page, reset zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      partner_r <= 16'h0000;
    end else if (page_rx_pulse) begin
      partner_r <= partner_word;
    end
  end

  // RULE3 RULE5 partner ability levels
  // registered once, so a read shows the level one cycle late
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lpnp_r <= 1'b0;
      lpan_r <= 1'b0;
    end else begin
      lpnp_r <= partner_np_able;
      lpan_r <= partner_an_able;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [ANNP_IRQ_W-1:0] ist_r;
  logic [ANNP_IRQ_W-1:0] ien_r;
  logic [ANNP_IRQ_W-1:0] iev;
  assign iev = {page_rx_pulse, par_det_fault};

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ist_r <= '0;
    end else begin
      ist_r <= (ist_r & ~(wr_clr ? reg_wdata[ANNP_IRQ_W-1:0] : '0)) | iev;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ien_r <= '0;
    end else if (wr_en) begin
      ien_r <= reg_wdata[ANNP_IRQ_W-1:0];
    end
  end

  // built from the next status value so the line rises with the status bit, not a cycle later
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((ist_r & ~(wr_clr ? reg_wdata[ANNP_IRQ_W-1:0] : '0)) | iev) & ien_r);
    end
  end

  // ----------------------------------------------------------------
  // read data, valid only the cycle after the strobe
  // ----------------------------------------------------------------
  logic [15:0] exp_word;
  logic [15:0] np_word;
  logic [15:0] rd_nxt;

  always_comb begin
    exp_word = 16'h0000;
    exp_word[ANNP_EXP_PDF_BIT] = pdf_r;
    exp_word[ANNP_EXP_LPNP_BIT] = lpnp_r;
    // RULE4 fixed local ability
    exp_word[ANNP_EXP_LDNP_BIT] = 1'b1;
    exp_word[ANNP_EXP_PR_BIT] = pr_r;
    exp_word[ANNP_EXP_LPAN_BIT] = lpan_r;
    np_word = 16'h0000;
    np_word[ANNP_NP_NEXT_BIT] = np_next_r;
    np_word[ANNP_NP_MSG_BIT] = np_msg_r;
    np_word[ANNP_NP_ACK2_BIT] = np_ack2_r;
    np_word[ANNP_NP_TOG_BIT] = tog_r;
    np_word[ANNP_NP_CODE_W-1:0] = np_code_r;
  end

  always_comb begin
    rd_nxt = 16'h0000;
    if (hit(reg_addr, ANNP_ADDR_EXPANSION)) begin
      rd_nxt = exp_word;
    end else if (hit(reg_addr, ANNP_ADDR_LOCAL_NP)) begin
      rd_nxt = np_word;
    end else if (hit(reg_addr, ANNP_ADDR_PARTNER_NP)) begin
      rd_nxt = partner_r;
    end else if (hit(reg_addr, ANNP_ADDR_IRQ_STATUS)) begin
      rd_nxt = 16'(ist_r);
    end else if (hit(reg_addr, ANNP_ADDR_IRQ_ENABLE)) begin
      rd_nxt = 16'(ien_r);
    end
  end

  // idle data is zero so a stale word is never taken for an answer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // outgoing page to the arbiter
  // ----------------------------------------------------------------
  // RULE8 message versus unformatted code selection
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      np_request <= ANNP_RST_NEXT;
      np_message <= ANNP_RST_MSG;
      np_ack2 <= ANNP_RST_ACK2;
      np_toggle <= 1'b0;
      np_code <= ANNP_RST_CODE;
      np_code_is_msg <= ANNP_RST_MSG;
    end else begin
      np_request <= np_next_r;
      np_message <= np_msg_r;
      np_ack2 <= np_ack2_r;
      np_toggle <= tog_r;
      np_code <= np_code_r;
      np_code_is_msg <= np_msg_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions: latched flags and abilities
  // ----------------------------------------------------------------
  a_pdf_latch: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
    par_det_fault |=> pdf_r) else $error("fault flag not latched");
  a_pdf_hold: assert property (@(posedge mclk) disable iff (!rst_b) // RULE1
    pdf_r && !rd_exp |=> pdf_r) else $error("fault flag dropped without a read");
  a_pr_latch: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
    page_rx_pulse |=> pr_r) else $error("page flag not latched");
  a_pr_hold: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
    pr_r && !rd_exp |=> pr_r) else $error("page flag dropped without a read");
  a_lpnp_follow: assert property (@(posedge mclk) disable iff (!rst_b) // RULE3
    reg_rd && hit(reg_addr, ANNP_ADDR_EXPANSION)
      |=> reg_rdata[ANNP_EXP_LPNP_BIT] == $past(partner_np_able, 2))
    else $error("partner np ability wrong");
  a_ldnp_one: assert property (@(posedge mclk) disable iff (!rst_b) // RULE4
    reg_rd && hit(reg_addr, ANNP_ADDR_EXPANSION)
      |=> reg_rdata[ANNP_EXP_LDNP_BIT])
    else $error("local np ability not one");
  a_lpan_follow: assert property (@(posedge mclk) disable iff (!rst_b) // RULE5
    reg_rd && hit(reg_addr, ANNP_ADDR_EXPANSION)
      |=> reg_rdata[ANNP_EXP_LPAN_BIT] == $past(partner_an_able, 2))
    else $error("partner autoneg ability wrong");
  a_exp_reserved: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rd && hit(reg_addr, ANNP_ADDR_EXPANSION)
      |=> reg_rdata[DATA_W-1:ANNP_EXP_PDF_BIT+1] == '0)
    else $error("expansion reserved bits not zero");
  // a read in the same cycle as a new event leaves the flag set
  a_clear_read: assert property (@(posedge mclk) disable iff (!rst_b) // RULE14
    rd_exp && !par_det_fault |=> !pdf_r) else $error("fault flag not cleared");
  a_pr_clear: assert property (@(posedge mclk) disable iff (!rst_b) // RULE14
    rd_exp && !page_rx_pulse |=> !pr_r) else $error("page flag not cleared");

  // ----------------------------------------------------------------
  // assertions: outgoing and received next page
  // ----------------------------------------------------------------
  a_np_write: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
    wr_np |=> ##1 np_request == $past(reg_wdata[ANNP_NP_NEXT_BIT], 2)
      && np_message == $past(reg_wdata[ANNP_NP_MSG_BIT], 2)
      && np_ack2 == $past(reg_wdata[ANNP_NP_ACK2_BIT], 2))
    else $error("next page write lost");
  a_code_kind: assert property (@(posedge mclk) disable iff (!rst_b) // RULE8
    wr_np |=> ##1 np_code_is_msg == $past(reg_wdata[ANNP_NP_MSG_BIT], 2))
    else $error("code kind mismatch");
  a_code_write: assert property (@(posedge mclk) disable iff (!rst_b) // RULE11
    wr_np |=> ##1 np_code == $past(reg_wdata[ANNP_NP_CODE_W-1:0], 2))
    else $error("code field write lost");
  a_toggle_inv: assert property (@(posedge mclk) disable iff (!rst_b) // RULE10
    page_exchanged |=> ##1 np_toggle == !$past(exchanged_toggle, 2))
    else $error("toggle not inverted");
  a_toggle_read: assert property (@(posedge mclk) disable iff (!rst_b) // RULE10
    page_exchanged ##2 (reg_rd && hit(reg_addr, ANNP_ADDR_LOCAL_NP) && !$past(page_exchanged))
      |=> reg_rdata[ANNP_NP_TOG_BIT] == !$past(exchanged_toggle, 3))
    else $error("toggle read back wrong");
  a_partner_ack: assert property (@(posedge mclk) disable iff (!rst_b) // RULE12
    page_rx_pulse ##2 (reg_rd && hit(reg_addr, ANNP_ADDR_PARTNER_NP) && !$past(page_rx_pulse))
      |=> reg_rdata[ANNP_NP_ACK_BIT] == $past(partner_word[ANNP_NP_ACK_BIT], 3))
    else $error("partner ack not shown");
  a_partner_bits: assert property (@(posedge mclk) disable iff (!rst_b) // RULE13
    page_rx_pulse ##2 (reg_rd && hit(reg_addr, ANNP_ADDR_PARTNER_NP) && !$past(page_rx_pulse))
      |=> reg_rdata[ANNP_NP_NEXT_BIT:ANNP_NP_TOG_BIT] == $past(partner_word[15:11], 3))
    else $error("partner control bits not shown");

  // ----------------------------------------------------------------
  // assertions: read port and interrupt
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == '0) else $error("read data not zero when idle");
  a_status_set: assert property (@(posedge mclk) disable iff (!rst_b)
    iev != '0 |=> (ist_r & $past(iev)) == $past(iev)) else $error("status bit not set");
  a_ien_write: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_en |=> ien_r == $past(reg_wdata[ANNP_IRQ_W-1:0])) else $error("enable write lost");
  a_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
    (|(ist_r & ien_r)) && !wr_clr |=> irq) else $error("interrupt missing");
  a_irq_off: assert property (@(posedge mclk) disable iff (!rst_b)
    ((ist_r | iev) & ien_r) == '0 |=> !irq) else $error("interrupt without enabled status");

  c_fault_read: cover property (@(posedge mclk) disable iff (!rst_b) par_det_fault ##[1:4] rd_exp);
  c_page_irq: cover property (@(posedge mclk) disable iff (!rst_b) page_rx_pulse ##2 irq);
  c_np_write: cover property (@(posedge mclk) disable iff (!rst_b) wr_np ##1 page_exchanged);
  c_partner_read: cover property (@(posedge mclk) disable iff (!rst_b)
    page_rx_pulse ##2 (reg_rd && hit(reg_addr, ANNP_ADDR_PARTNER_NP)));
  c_fault_held: cover property (@(posedge mclk) disable iff (!rst_b) par_det_fault && rd_exp);

endmodule
`default_nettype wire

// >>> annp_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// link partner autoneg logic, behavioural
// ----------------------------------------
module annp_partner_model (
  input wire logic mclk,
  input wire logic rst_b,
  output logic page_rx_pulse,
  output logic [15:0] partner_word,
  output logic page_exchanged,
  output logic exchanged_toggle,
  output logic par_det_fault,
  output logic partner_np_able,
  output logic partner_an_able
);
  // quiet link while reset is held; a reset also drops any pending pulse
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      page_rx_pulse <= 1'b0;
      partner_word <= 16'h0000;
      page_exchanged <= 1'b0;
      exchanged_toggle <= 1'b0;
      par_det_fault <= 1'b0;
      partner_np_able <= 1'b0;
      partner_an_able <= 1'b0;
    end
  end
  // word is only valid with the pulse; afterwards show its inverse so stale capture is seen
  task automatic send_page(input logic [15:0] w);
    @(posedge mclk);
    page_rx_pulse <= 1'b1;
    page_exchanged <= 1'b1;
    partner_word <= w;
    exchanged_toggle <= w[11];
    @(posedge mclk);
    page_rx_pulse <= 1'b0;
    page_exchanged <= 1'b0;
    partner_word <= ~w;
    exchanged_toggle <= ~w[11];
  endtask
  task automatic set_fault(input logic f);
    @(posedge mclk);
    par_det_fault <= f;
  endtask
  task automatic set_able(input logic np, input logic an);
    @(posedge mclk);
    partner_np_able <= np;
    partner_an_able <= an;
  endtask
endmodule
`default_nettype wire

// >>> annp_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module annp_regs_tb;
  import annp_pkg::*;
  logic mclk, rst_b, reg_wr, reg_rd, pdf, prx, pnp, pan, pex, ptog, irq;
  logic np_request, np_message, np_ack2, np_toggle, np_code_is_msg;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pword;
  logic [10:0] np_code;
  int bad_count, checks, cycles;
  annp_partner_model i_partner (.mclk(mclk), .rst_b(rst_b), .page_rx_pulse(prx),
    .partner_word(pword),
    .page_exchanged(pex), .exchanged_toggle(ptog), .par_det_fault(pdf),
    .partner_np_able(pnp), .partner_an_able(pan));
  annp_regs i_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .par_det_fault(pdf),
    .page_rx_pulse(prx), .partner_np_able(pnp), .partner_an_able(pan), .partner_word(pword),
    .page_exchanged(pex), .exchanged_toggle(ptog), .np_request(np_request),
    .np_message(np_message), .np_ack2(np_ack2), .np_toggle(np_toggle), .np_code(np_code),
    .np_code_is_msg(np_code_is_msg), .irq(irq));
  // ----------------------------------------
  // clock, timeout, bus tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // whole run is under a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] ex, input string nm);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata)
  endtask
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(5'h06, 16'h0004, "expansion");
    rdc(5'h07, 16'h2001, "local page");
    rdc(5'h08, 16'h0000, "partner page");
    `CHK("np message", 1'b1, np_message)
    `CHK("np is msg", 1'b1, np_code_is_msg)
    $display("test reset done");
  endtask
  task automatic t_write();
    wr(5'h07, 16'hFFFF);
    settle();
    `CHK("np request", 1'b1, np_request)
    `CHK("np ack2", 1'b1, np_ack2)
    rdc(5'h07, 16'hB7FF, "local page");
    wr(5'h07, 16'h0123);
    settle();
    `CHK("np is msg", 1'b0, np_code_is_msg)
    `CHK("np message", 1'b0, np_message)
    `CHK("np code", 11'h123, np_code)
    $display("test write done");
  endtask
  task automatic t_page();
    i_partner.send_page(16'hF8AA);
    rdc(5'h08, 16'hF8AA, "partner page");
    rdc(5'h06, 16'h0006, "expansion");
    rdc(5'h06, 16'h0004, "expansion");
    rdc(5'h07, 16'h0123, "local page");
    i_partner.send_page(16'h0155);
    rdc(5'h07, 16'h0923, "local page");
    settle();
    `CHK("np toggle", 1'b1, np_toggle)
    $display("test page done");
  endtask
  task automatic t_fault();
    i_partner.set_able(1'b1, 1'b1);
    i_partner.set_fault(1'b1);
    i_partner.set_fault(1'b0);
    rdc(5'h06, 16'h001F, "expansion");
    rdc(5'h06, 16'h000D, "expansion");
    i_partner.set_fault(1'b1);
    rdc(5'h06, 16'h001D, "expansion");
    rdc(5'h06, 16'h001D, "expansion");
    i_partner.set_fault(1'b0);
    rdc(5'h06, 16'h001D, "expansion");
    rdc(5'h06, 16'h000D, "expansion");
    i_partner.set_able(1'b0, 1'b0);
    rdc(5'h06, 16'h0004, "expansion");
    $display("test fault done");
  endtask
  task automatic t_irq();
    wr(5'h06, 16'hFFFF);
    rdc(5'h06, 16'h0004, "expansion");
    rdc(5'h1F, 16'h0000, "unmapped");
    wr(5'h19, 16'h0003);
    wr(5'h1A, 16'h0003);
    i_partner.send_page(16'h0800);
    rdc(5'h18, 16'h0002, "irq status");
    `CHK("irq", 1'b1, irq)
    wr(5'h19, 16'h0002);
    settle();
    `CHK("irq", 1'b0, irq)
    wr(5'h1A, 16'h0001);
    i_partner.send_page(16'h0000);
    rdc(5'h18, 16'h0002, "irq status");
    `CHK("irq", 1'b0, irq)
    $display("test irq done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_write();
    t_page();
    t_fault();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
